// [design/lsic_pkg.sv]
// package: constants and types for the led sink i2c control block
// Notes on behaviour
// - only writes accepted; reads are never acknowledged
// - two registers decoded: 00h and 01h
// - upper nibble backlight code, lower aux
// - code selects current fraction from table
// - enable bits D4..D0 map to sinks
// - level per group, on/off per sink
// - current limit halts switching while exceeded
// - over-temperature turns off both power switches
// - over-voltage halts switching until below hysteresis
// - disconnect closes on valid supply and enable
// - soft start waits for supply lockout release
// - respond only to target address 36h
// - acknowledge address, register and data bytes
package lsic_pkg;
	localparam logic [6:0] TARGET_ADDR      = 7'h36;
	localparam logic [7:0] REG_BRIGHT_ADDR  = 8'h00;
	localparam logic [7:0] REG_ENABLE_ADDR  = 8'h01;
	localparam logic [7:0] BRIGHT_RESET     = 8'h00;
	localparam logic [7:0] ENABLE_RESET     = 8'h00;
	localparam int         BL_CODE_MSB      = 7;
	localparam int         BL_CODE_LSB      = 4;
	localparam int         AUX_CODE_MSB     = 3;
	localparam int         AUX_CODE_LSB     = 0;
	localparam int         EN_MASK_MSB      = 4;
	// soft-start charge time and derived cycle count at 25 MHz
	localparam int         SOFT_START_US    = 300;
	localparam int         CLK_MHZ          = 25;
	localparam int         SOFT_START_CYC   = SOFT_START_US * CLK_MHZ;
	// protocol phases, one-hot
	typedef enum logic [4:0] {
		LSIC_IDLE = 5'b0_0001,
		LSIC_ADDR = 5'b0_0010,
		LSIC_REG  = 5'b0_0100,
		LSIC_DATA = 5'b0_1000,
		LSIC_SKIP = 5'b1_0000
	} lsic_phase_e;
	// per-sink on/off outputs
	typedef struct packed {
		logic backlight_sink_first_on;
		logic backlight_sink_second_on;
		logic aux_sink_first_on;
		logic aux_sink_second_on;
		logic aux_sink_third_on;
	} lsic_sink_s;
	// analog comparator inputs
	typedef struct packed {
		logic supply_ok;         // supply lockout released
		logic current_over;      // switch current above limit
		logic temp_over;         // junction at shutdown threshold
		logic temp_cool;         // junction below threshold minus hysteresis
		logic overvoltage_sense; // sense above upper threshold
		logic ov_below_low;      // sense below lower hysteresis level
	} lsic_sense_s;
endpackage

// [design/lsic_top.sv]
// module: i2c write-only target with led register bank and power gating
`timescale 1ns/10ps
module lsic_top #(
	parameter int SOFT_START_CYCLES = lsic_pkg::SOFT_START_CYC
) (
	input  wire logic               core_clk_i,
	input  wire logic               resetn_i,
	input  wire logic               scl_i,
	input  wire logic               sda_i,
	output logic                    sda_o,
	output logic                    sda_oe_o,
	input  wire logic               enable_i,
	input  wire lsic_pkg::lsic_sense_s sense_i,
	output logic [3:0]              backlight_level_code_o,
	output logic [3:0]              aux_level_code_o,
	output logic [7:0]              backlight_fraction_o,
	output logic [7:0]              aux_fraction_o,
	output lsic_pkg::lsic_sink_s    sink_on_o,
	output logic                    disconnect_on_o,
	output logic                    switch_allow_o,
	output logic                    switch_off_o
);
	////////////////////////////////////////////////////////////////////////////////
	// fraction of full scale in half percent units
	function automatic logic [7:0] lsic_fraction(input logic [3:0] code);
		case (code)
			4'h0: lsic_fraction = 8'h00C8;
			4'h1: lsic_fraction = 8'h00A8;
			4'h2: lsic_fraction = 8'h008E;
			4'h3: lsic_fraction = 8'h0078;
			4'h4: lsic_fraction = 8'h0066;
			4'h5: lsic_fraction = 8'h0056;
			4'h6: lsic_fraction = 8'h0046;
			4'h7: lsic_fraction = 8'h003E;
			4'h8: lsic_fraction = 8'h0034;
			4'h9: lsic_fraction = 8'h002A;
			4'hA: lsic_fraction = 8'h0024;
			4'hB: lsic_fraction = 8'h001E;
			4'hC: lsic_fraction = 8'h001B;
			4'hD: lsic_fraction = 8'h0018;
			4'hE: lsic_fraction = 8'h0015;
			default: lsic_fraction = 8'h0012;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, two flops each
	logic [1:0] scl_sync;   // scl chain
	logic [1:0] sda_sync;   // sda chain
	logic [1:0] en_sync;    // enable chain
	logic       scl_d;      // delayed synced scl
	logic       sda_d;      // delayed synced sda
	logic [1:0] next_scl_sync;
	logic [1:0] next_sda_sync;
	logic [1:0] next_en_sync;
	always_comb begin
		next_scl_sync = {scl_sync[0], scl_i};
		next_sda_sync = {sda_sync[0], sda_i};
		next_en_sync  = {en_sync[0], enable_i};
	end
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			en_sync  <= 2'h0;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
		end else begin
			scl_sync <= next_scl_sync;
			sda_sync <= next_sda_sync;
			en_sync  <= next_en_sync;
			scl_d    <= scl_sync[1];
			sda_d    <= sda_sync[1];
		end
	end
	// bus events from the synced pins
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	assign scl_rise = scl_sync[1] & ~scl_d;
	assign scl_fall = ~scl_sync[1] & scl_d;
	assign start_c  = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
	assign stop_c   = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

	////////////////////////////////////////////////////////////////////////////////
	// byte receiver and protocol state
	lsic_pkg::lsic_phase_e phase;      // current phase
	logic [3:0]            bit_cnt;    // bits received in byte, 9 = ack slot
	logic [7:0]            shift;      // incoming byte, msb first
	logic [7:0]            reg_ptr;    // latched register address
	logic                  ack_drive;  // pulling sda low
	logic [7:0]            bright;     // brightness register
	logic [7:0]            enables;    // enable register
	lsic_pkg::lsic_phase_e next_phase;
	logic [3:0]            next_bit_cnt;
	logic [7:0]            next_shift;
	logic [7:0]            next_reg_ptr;
	logic                  next_ack_drive;
	logic [7:0]            next_bright;
	logic [7:0]            next_enables;
	logic [7:0]            full_byte;  // shift value with the bit sampled on this rise
	always_comb begin
		next_phase     = phase;
		next_bit_cnt   = bit_cnt;
		next_shift     = shift;
		next_reg_ptr   = reg_ptr;
		next_ack_drive = ack_drive;
		next_bright    = bright;
		next_enables   = enables;
		full_byte      = {shift[6:0], sda_sync[1]};
		if (start_c) begin
			// start or repeated start
			next_phase     = lsic_pkg::LSIC_ADDR;
			next_bit_cnt   = 4'h0;
			next_ack_drive = 1'b0;
		end else if (stop_c) begin
			next_phase     = lsic_pkg::LSIC_IDLE;
			next_ack_drive = 1'b0;
		end else if (phase != lsic_pkg::LSIC_IDLE && phase != lsic_pkg::LSIC_SKIP) begin
			if (scl_rise && bit_cnt < 4'h8) begin
				// sample on rising scl, msb first
				next_shift   = full_byte;
				next_bit_cnt = bit_cnt + 4'h1;
			end else if (scl_fall && bit_cnt == 4'h8) begin
				// eighth bit done: decide ack for ninth clock
				case (phase)
					lsic_pkg::LSIC_ADDR: begin
						if (shift[7:1] == lsic_pkg::TARGET_ADDR && !shift[0]) begin
							next_ack_drive = 1'b1;
							next_phase     = lsic_pkg::LSIC_REG;
						end else begin
							next_phase     = lsic_pkg::LSIC_SKIP;
						end
					end
					lsic_pkg::LSIC_REG: begin
						next_ack_drive = 1'b1;
						next_reg_ptr   = shift;
						next_phase     = lsic_pkg::LSIC_DATA;
					end
					lsic_pkg::LSIC_DATA: begin
						next_ack_drive = 1'b1;
						if (reg_ptr == lsic_pkg::REG_BRIGHT_ADDR) begin
							next_bright = shift;
						end else if (reg_ptr == lsic_pkg::REG_ENABLE_ADDR) begin
							next_enables = {3'h0, shift[lsic_pkg::EN_MASK_MSB:0]};
						end
						next_phase = lsic_pkg::LSIC_REG;
					end
					default: next_phase = lsic_pkg::LSIC_IDLE;
				endcase
				next_bit_cnt = 4'h9;
			end else if (scl_fall && bit_cnt == 4'h9) begin
				// ninth clock over: release sda
				next_ack_drive = 1'b0;
				next_bit_cnt   = 4'h0;
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			phase     <= lsic_pkg::LSIC_IDLE;
			bit_cnt   <= 4'h0;
			shift     <= 8'h00;
			reg_ptr   <= 8'h00;
			ack_drive <= 1'b0;
			bright    <= lsic_pkg::BRIGHT_RESET;
			enables   <= lsic_pkg::ENABLE_RESET;
		end else begin
			phase     <= next_phase;
			bit_cnt   <= next_bit_cnt;
			shift     <= next_shift;
			reg_ptr   <= next_reg_ptr;
			ack_drive <= next_ack_drive;
			bright    <= next_bright;
			enables   <= next_enables;
		end
	end
	// open drain: drive low only during ack
	assign sda_o    = 1'b0;
	assign sda_oe_o = ack_drive;

	////////////////////////////////////////////////////////////////////////////////
	// register fields to sink controls
	assign backlight_level_code_o = bright[lsic_pkg::BL_CODE_MSB:lsic_pkg::BL_CODE_LSB];
	assign aux_level_code_o       = bright[lsic_pkg::AUX_CODE_MSB:lsic_pkg::AUX_CODE_LSB];
	assign backlight_fraction_o   = lsic_fraction(backlight_level_code_o);
	assign aux_fraction_o         = lsic_fraction(aux_level_code_o);
	assign sink_on_o              = enables[lsic_pkg::EN_MASK_MSB:0];

	////////////////////////////////////////////////////////////////////////////////
	// power gating: disconnect, soft start, protections
	logic        disc_on;    // disconnect switch closed
	logic        hot;        // thermal shutdown latched
	logic        ov_hold;    // over-voltage latched
	logic [15:0] ss_cnt;     // output charge timer
	logic        next_disc_on;
	logic        next_hot;
	logic        next_ov_hold;
	logic [15:0] next_ss_cnt;
	logic        ss_done;
	assign ss_done = (ss_cnt >= 16'(SOFT_START_CYCLES));
	always_comb begin
		next_disc_on = sense_i.supply_ok & en_sync[1];
		next_ss_cnt  = ss_cnt;
		if (!next_disc_on) begin
			next_ss_cnt = 16'h0000;
		end else if (!ss_done) begin
			next_ss_cnt = ss_cnt + 16'h0001;
		end
		next_hot = hot;
		if (sense_i.temp_over) begin
			next_hot = 1'b1;
		end else if (sense_i.temp_cool) begin
			next_hot = 1'b0;
		end
		next_ov_hold = ov_hold;
		if (sense_i.overvoltage_sense) begin
			next_ov_hold = 1'b1;
		end else if (sense_i.ov_below_low) begin
			next_ov_hold = 1'b0;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			disc_on <= 1'b0;
			hot     <= 1'b0;
			ov_hold <= 1'b0;
			ss_cnt  <= 16'h0000;
		end else begin
			disc_on <= next_disc_on;
			hot     <= next_hot;
			ov_hold <= next_ov_hold;
			ss_cnt  <= next_ss_cnt;
		end
	end
	assign disconnect_on_o = disc_on & ~hot;
	assign switch_allow_o  = disc_on & ss_done & ~hot & ~ov_hold & ~sense_i.current_over;
	assign switch_off_o    = ~switch_allow_o;

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	read_never_acked_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(phase == lsic_pkg::LSIC_ADDR && scl_fall && bit_cnt == 4'h8 && shift[0])
		|=> !ack_drive) else $error("read address acked");
	addr_match_ack_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(phase == lsic_pkg::LSIC_ADDR && scl_fall && bit_cnt == 4'h8 &&
		 shift == {lsic_pkg::TARGET_ADDR, 1'b0}) |=> ack_drive) else $error("no address ack");
	wrong_addr_skip_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(phase == lsic_pkg::LSIC_ADDR && scl_fall && bit_cnt == 4'h8 &&
		 shift[7:1] != lsic_pkg::TARGET_ADDR) |=> phase == lsic_pkg::LSIC_SKIP)
		else $error("foreign address not skipped");
	bright_write_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(phase == lsic_pkg::LSIC_DATA && scl_fall && bit_cnt == 4'h8 &&
		 reg_ptr == lsic_pkg::REG_BRIGHT_ADDR) |=> bright == $past(shift))
		else $error("brightness not written");
	enable_mask_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		enables[7:5] == 3'h0) else $error("enable upper bits set");
	ack_release_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		$fell(ack_drive) |-> ($past(stop_c) || $past(start_c) || $past(bit_cnt) == 4'h9))
		else $error("ack released early");
	overcurrent_halt_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		sense_i.current_over |-> !switch_allow_o) else $error("switching over limit");
	thermal_off_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		sense_i.temp_over |=> (!switch_allow_o && !disconnect_on_o))
		else $error("hot but switching");
	ov_halt_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		sense_i.overvoltage_sense |=> !switch_allow_o) else $error("ov but switching");
	lockout_hold_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		!sense_i.supply_ok |=> (!disconnect_on_o && ss_cnt == 16'h0000))
		else $error("started in lockout");
	restart_cov_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		start_c && phase != lsic_pkg::LSIC_IDLE);
	write_cov_c:  cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		$changed(bright));
	enable_cov_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		$changed(enables));
	switch_cov_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		$rose(switch_allow_o));
endmodule

// [dv/lsic_i2c_master.sv]
// i2c bus master model: drives scl, pulls sda low for zeros
`timescale 1ns/10ps
module lsic_i2c_master (
	input  wire logic core_clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_pull_o
);
	// bus idle: scl high, sda released
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	// quarter scl period, changes land just after a core edge
	task automatic quarter();
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask
	// start: sda falls while scl high
	task automatic start();
		quarter();
		sda_pull_o = 1'b1;
		quarter();
		scl_o = 1'b0;
	endtask
	// one bit: sda set while scl low, held over the high phase
	task automatic put_bit(input logic b, output logic seen);
		quarter();
		sda_pull_o = ~b;
		quarter();
		scl_o = 1'b1;
		quarter();
		seen = sda_i;
		quarter();
		scl_o = 1'b0;
	endtask
	// byte msb first, then a released ninth bit for the ack
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], s);
		end
		put_bit(1'b1, s);
		ack = ~s;
	endtask
	// after an ack: release sda, raise scl, ready for a repeated start
	task automatic restart_prep();
		quarter();
		sda_pull_o = 1'b0;
		quarter();
		scl_o = 1'b1;
	endtask
	// stop: sda rises while scl high, scl then stands still
	task automatic stop();
		quarter();
		sda_pull_o = 1'b1;
		quarter();
		scl_o = 1'b1;
		quarter();
		sda_pull_o = 1'b0;
		quarter();
	endtask
endmodule

// [dv/tb_lsic_top.sv]
// testbench for the led sink i2c control block
`timescale 1ns/10ps
module tb_lsic_top;
	logic                  core_clk_i;   // 25 mhz core clock
	logic                  resetn_i;     // sync reset, active low
	logic                  scl;          // scl from the master model
	logic                  pull;         // master pulling sda low
	logic                  sda;          // resolved sda wire
	logic                  dut_sda;      // design data level
	logic                  dut_oe;       // design pulling sda
	logic                  enable_i;     // enable pin
	lsic_pkg::lsic_sense_s sense_i;      // comparator levels
	logic [3:0]            bl_code;      // backlight level code
	logic [3:0]            aux_code;     // aux level code
	logic [7:0]            bl_frac;      // backlight fraction
	logic [7:0]            aux_frac;     // aux fraction
	lsic_pkg::lsic_sink_s  sink_on;      // per-sink enables
	logic                  disc;         // disconnect closed
	logic                  allow;        // converter may switch
	logic                  off;          // switches held off
	int                    num_errors;   // mismatches seen
	int                    total_checks; // comparisons made
	logic [7:0]            frac_tab [16]; // half-percent table
	logic                  rs_ack;       // ack seen before a repeated start
	////////////////////////////////////////
	// open drain wire with pull-up: low if anyone pulls
	assign sda = (pull | (dut_oe & ~dut_sda)) ? 1'b0 : 1'b1;
	lsic_top #(.SOFT_START_CYCLES(20)) DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.scl_i(scl), .sda_i(sda), .sda_o(dut_sda), .sda_oe_o(dut_oe), .enable_i(enable_i),
		.sense_i(sense_i), .backlight_level_code_o(bl_code), .aux_level_code_o(aux_code),
		.backlight_fraction_o(bl_frac), .aux_fraction_o(aux_frac), .sink_on_o(sink_on),
		.disconnect_on_o(disc), .switch_allow_o(allow), .switch_off_o(off));
	lsic_i2c_master M (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
	// clock generator
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	////////////////////////////////////////
	// compare seen against expected
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic end_of_test();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// n core edges, then a small skew
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	// one transfer: address byte then n body bytes from the top
	task automatic xfer(input logic [7:0] first, input logic [31:0] body, input int n,
		input logic exp_ack);
		logic ack;
		M.start();
		M.send_byte(first, ack);
		check({7'h0, ack}, {7'h0, exp_ack});
		for (int k = 0; k < n; k++) begin
			M.send_byte(body[31 - 8 * k -: 8], ack);
			check({7'h0, ack}, {7'h0, exp_ack});
		end
		M.stop();
	endtask
	// hang guard
	initial begin
		#2_000_000;
		num_errors++;
		end_of_test();
	end
	// main sequence
	initial begin
		num_errors = 0;
		total_checks = 0;
		frac_tab = '{8'hC8, 8'hA8, 8'h8E, 8'h78, 8'h66, 8'h56, 8'h46, 8'h3E,
			8'h34, 8'h2A, 8'h24, 8'h1E, 8'h1B, 8'h18, 8'h15, 8'h12};
		resetn_i = 1'b0;
		enable_i = 1'b0;
		sense_i = '0;
		step(10);
		resetn_i = 1'b1;
		step(3);
		check({bl_code, aux_code}, 8'h00);
		check({3'h0, sink_on}, 8'h00);
		check({6'h0, disc, allow}, 8'h00);
		// every code in both groups, groups set apart
		for (int i = 0; i < 16; i++) begin
			xfer(8'h6C, {8'h00, 4'(i), 4'(15 - i), 16'h0000}, 2, 1'b1);
			check({bl_code, aux_code}, {4'(i), 4'(15 - i)});
			check(bl_frac, frac_tab[i]);
			check(aux_frac, frac_tab[15 - i]);
		end
		// walking one over the sinks, top bits set and dropped
		for (int b = 0; b < 5; b++) begin
			xfer(8'h6C, {8'h01, 8'hE0 | 8'(1 << b), 16'h0000}, 2, 1'b1);
			check({3'h0, sink_on}, 8'(1 << b));
		end
		// two pairs in one transfer
		xfer(8'h6C, 32'h0005_011D, 4, 1'b1);
		check({bl_code, aux_code}, 8'h05);
		check({3'h0, sink_on}, 8'h1D);
		// unmapped register, register byte without data, foreign address, read
		xfer(8'h6C, 32'h0255_0000, 2, 1'b1);
		xfer(8'h6C, 32'h0000_0000, 1, 1'b1);
		xfer(8'h6E, 32'h00AA_01AA, 4, 1'b0);
		xfer(8'h6D, 32'h00AA_01AA, 4, 1'b0);
		check({bl_code, aux_code}, 8'h05);
		check({3'h0, sink_on}, 8'h1D);
		// repeated start: first pair lands, second transfer follows without stop
		M.start();
		M.send_byte(8'h6C, rs_ack);
		M.send_byte(8'h00, rs_ack);
		M.send_byte(8'h3C, rs_ack);
		check({7'h0, rs_ack}, 8'h01);
		M.restart_prep();
		xfer(8'h6C, 32'h0107_0000, 2, 1'b1);
		check({bl_code, aux_code}, 8'h3C);
		check({3'h0, sink_on}, 8'h07);
		// power gating: enable without supply stays open
		enable_i = 1'b1;
		step(6);
		check({6'h0, disc, allow}, 8'h00);
		sense_i.supply_ok = 1'b1;
		step(6);
		check({6'h0, disc, allow}, 8'h02);
		step(40);
		check({6'h0, allow, off}, 8'h02);
		sense_i.current_over = 1'b1;
		step(2);
		check({6'h0, allow, off}, 8'h01);
		sense_i.current_over = 1'b0;
		step(2);
		check({7'h0, allow}, 8'h01);
		sense_i.overvoltage_sense = 1'b1;
		step(2);
		sense_i.overvoltage_sense = 1'b0;
		step(4);
		check({7'h0, allow}, 8'h00);
		sense_i.ov_below_low = 1'b1;
		step(4);
		check({7'h0, allow}, 8'h01);
		sense_i.ov_below_low = 1'b0;
		sense_i.temp_over = 1'b1;
		step(2);
		sense_i.temp_over = 1'b0;
		step(4);
		check({6'h0, allow, off}, 8'h01);
		check({6'h0, disc, allow}, 8'h00);
		sense_i.temp_cool = 1'b1;
		step(50);
		check({6'h0, allow, off}, 8'h02);
		end_of_test();
	end
endmodule
